// [dv/serial_peer.sv]
/* Serial peer model: sends a byte queue and records what it receives.
   Assumes the bench feeds it the resolved serial clock and data levels. */
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
    // Link
    input  wire logic sck,
    input  wire logic tx,
    output var  logic rx,
    // Control
    input  wire logic flush
);
    logic [7:0] send_q[$];
    logic [7:0] got_q[$];
    logic [7:0] cur;
    logic [7:0] shreg;
    int         tcnt;
    int         rcnt;
    initial rx = 1'b1;
    always @(posedge flush) begin
        tcnt = 0;
        rcnt = 0;
        got_q.delete();
    end
    // Data moves after a fall so it is settled by the rise
    always @(negedge sck) begin
        if (tcnt == 0)
            cur = (send_q.size() > 0) ? send_q.pop_front() : 8'hA5;
        rx <= cur[tcnt];
        tcnt = (tcnt + 1) % 8;
    end
    always @(posedge sck) begin
        shreg = {tx, shreg[7:1]};
        rcnt = rcnt + 1;
        if (rcnt == 8) begin
            got_q.push_back(shreg);
            rcnt = 0;
        end
    end
endmodule // serial_peer
`default_nettype wire

// [dv/tb_top.sv]
/* Self-checking bench for the buffered serial port.
   Assumes the peer model and a 200 MHz APB master run by this bench. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sck_out;
    logic        sck_oe;
    logic        rx;
    logic        tx;
    logic        tx_oe;
    logic        stb;
    logic        cs_n;
    logic        ext_clk;
    logic        flush;
    logic        perr;
    logic        prev_stb;
    int          num_errors;
    int          compares;
    int          lowc;
    int          gapc;
    int          stbs;
    int          badg;
    // Floating lines are taken as pulled high
    wire         sck_w = sck_oe ? sck_out : ext_clk;
    wire         tx_w = tx_oe ? tx : 1'b1;

    buffered_serial_unit uut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_out),
        .serial_clock_pin_oe(sck_oe), .serial_rx_pin(rx),
        .serial_tx_pin(tx), .serial_tx_pin_oe(tx_oe),
        .byte_strobe_pin(stb), .chip_select_n(cs_n));
    serial_peer peer (.sck(sck_w), .tx(tx_w), .rx(rx), .flush(flush));

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (sck_oe && !sck_out) lowc++;
        if (stb) gapc++;
        if (stb && !prev_stb) stbs++;
        if (stb && !sck_out) badg++;
        prev_stb = stb;
    end

    task automatic complete_run();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            complete_run();
        end
    endtask
    task automatic wait_idle();
        logic [7:0] s;
        for (int k = 0; k < 400; k++) begin
            apb(1'b0, 16'hFFA7, 8'h00, s);
            if (s[0] === 1'b0) return;
            repeat (20) @(posedge clk);
        end
        num_errors++;
        complete_run();
    endtask
    task automatic flush_mon();
        lowc = 0;
        gapc = 0;
        stbs = 0;
        badg = 0;
        flush <= 1'b1;
        @(posedge clk);
        flush <= 1'b0;
    endtask
    task automatic t_regs();
        logic [7:0] d;
        for (int i = 4; i < 8; i++) begin
            apb(1'b0, 16'hFFA0 + 16'(i), 8'h00, d);
            chk(d, 8'hE0);
        end
        apb(1'b1, 16'hFFA4, 8'h0B, d);
        apb(1'b0, 16'hFFA4, 8'h00, d);
        chk(d, 8'hEB);
        apb(1'b1, 16'hFFA5, 8'h1F, d);
        apb(1'b0, 16'hFFA5, 8'h00, d);
        chk(d, 8'hFF);
        apb(1'b1, 16'hFF40, 8'h11, d);
        chk(perr, 1'b1);
        $display("test regs done");
    endtask
    task automatic t_xfer(input logic [1:0] gap, input logic [2:0] cks,
                          input logic [4:0] first, input logic [4:0] last);
        int n;
        int half;
        int glen;
        logic [7:0] d;
        n = int'(5'(last - first)) + 1;
        half = (cks == 3'h0) ? 128 : (64 >> cks);
        glen = (gap == 2'h0) ? 0 : (gap == 2'h1) ? 8 : (gap == 2'h2) ? 24 : 56;
        for (int i = 0; i < n; i++) begin
            apb(1'b1, 16'hFF80 + 16'(5'(first + i)), 8'h30 + 8'(i), d);
            peer.send_q.push_back(8'hC0 + 8'(i));
        end
        apb(1'b1, 16'hFFA4, {3'h0, first}, d);
        apb(1'b1, 16'hFFA5, {3'h0, last}, d);
        apb(1'b1, 16'hFFA6, {3'h0, gap, cks}, d);
        flush_mon();
        apb(1'b1, 16'hFFA7, 8'h01, d);
        wait_idle();
        for (int i = 0; i < n; i++) begin
            chk(peer.got_q[i], 8'h30 + 8'(i));
            apb(1'b0, 16'hFF80 + 16'(5'(first + i)), 8'h00, d);
            chk(d, 8'hC0 + 8'(i));
        end
        chk(peer.got_q.size(), n);
        chk(lowc, 8 * n * half);
        chk(stbs, (glen == 0) ? 0 : n - 1);
        chk(gapc, (n - 1) * glen * 2 * half);
        chk(badg, 0);
        $display("test xfer done");
    endtask
    task automatic t_wait();
        logic [7:0] d;
        apb(1'b1, 16'hFF81, 8'h5A, d);
        apb(1'b1, 16'hFFA4, 8'h01, d);
        apb(1'b1, 16'hFFA5, 8'h01, d);
        apb(1'b1, 16'hFFA6, 8'h00, d);
        apb(1'b1, 16'hFFA7, 8'h01, d);
        apb(1'b0, 16'hFFA7, 8'h00, d);
        chk(d[0], 1'b1);
        apb(1'b0, 16'hFF81, 8'h00, d);
        chk(d, 8'h00);
        apb(1'b1, 16'hFF81, 8'h77, d);
        apb(1'b0, 16'hFFA7, 8'h00, d);
        chk(d[2], 1'b1);
        apb(1'b1, 16'hFFA7, 8'h00, d);
        apb(1'b0, 16'hFF81, 8'h00, d);
        chk(d, 8'h5A);
        $display("test wait done");
    endtask
    task automatic t_abort();
        logic [7:0] d;
        apb(1'b1, 16'hFFA8, 8'h01, d);
        apb(1'b1, 16'hFFA6, 8'h06, d);
        cs_n <= 1'b1;
        apb(1'b1, 16'hFFA7, 8'h01, d);
        apb(1'b0, 16'hFFA7, 8'h00, d);
        chk(d[0], 1'b1);
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({sck_oe, tx_oe}, 2'b00);
        apb(1'b0, 16'hFFA7, 8'h00, d);
        chk(d[1:0], 2'b10);
        apb(1'b1, 16'hFFA7, 8'h00, d);
        apb(1'b1, 16'hFFA8, 8'h00, d);
        cs_n <= 1'b0;
        chk({sck_oe, tx_oe}, 2'b11);
        $display("test abort done");
    endtask
    task automatic pulses(input int k);
        for (int i = 0; i < k; i++) begin
            ext_clk <= 1'b0;
            repeat (4) @(posedge clk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic t_ext();
        logic [7:0] d;
        apb(1'b1, 16'hFFA6, 8'h0F, d);
        @(posedge clk);
        chk(sck_oe, 1'b0);
        apb(1'b1, 16'hFFA4, 8'h00, d);
        apb(1'b1, 16'hFFA5, 8'h01, d);
        flush_mon();
        apb(1'b1, 16'hFFA7, 8'h01, d);
        // Clock only once the first byte is loaded
        repeat (4) @(posedge clk);
        pulses(16);
        wait_idle();
        chk(stbs, 0);
        chk(peer.got_q.size(), 2);
        chk(peer.got_q[0], 8'hC0);
        chk(peer.got_q[1], 8'h5A);
        apb(1'b0, 16'hFF80, 8'h00, d);
        chk(d, 8'hA5);
        pulses(1);
        apb(1'b0, 16'hFFA7, 8'h00, d);
        chk(d[3], 1'b1);
        apb(1'b1, 16'hFFA7, 8'h00, d);
        apb(1'b1, 16'hFFA6, 8'h06, d);
        @(posedge clk);
        chk(sck_oe, 1'b1);
        $display("test ext done");
    endtask

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cs_n = 1'b0;
        ext_clk = 1'b1;
        flush = 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_xfer(2'h0, 3'h6, 5'd5, 5'd5);
        t_xfer(2'h1, 3'h6, 5'd10, 5'd12);
        t_xfer(2'h2, 3'h5, 5'd30, 5'd1);
        t_xfer(2'h3, 3'h4, 5'd0, 5'd1);
        t_xfer(2'h0, 3'h0, 5'd7, 5'd7);
        t_xfer(2'h0, 3'h1, 5'd2, 5'd2);
        t_xfer(2'h0, 3'h2, 5'd3, 5'd3);
        t_xfer(2'h1, 3'h3, 5'd4, 5'd5);
        t_wait();
        t_abort();
        t_ext();
        complete_run();
    end
endmodule // tb_top
`default_nettype wire

// [hw/buffered_serial_unit.sv]
/*
 * Buffered synchronous serial port: 32-byte buffer, pointer registers,
 * clock divider, gap and strobe logic, chip-select abort, APB slave.
 * Assumes pins synchronous to clk and an APB master with one clock.
 */
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module buffered_serial_unit #(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      resetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [sbuf_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Serial link pins
    input  wire logic                      serial_clock_pin_in,
    output logic                           serial_clock_pin_out,
    output logic                           serial_clock_pin_oe,
    input  wire logic                      serial_rx_pin,
    output logic                           serial_tx_pin,
    output logic                           serial_tx_pin_oe,
    output logic                           byte_strobe_pin,
    input  wire logic                      chip_select_n
);

    typedef struct packed {
        sbuf_pkg::port_state_t  state;
        logic [4:0]             start_ptr;
        logic [4:0]             end_ptr;
        logic [1:0]             gap;
        logic [2:0]             cks;
        logic                   cs_mode;
        logic                   tx;
        logic                   orer;
        logic                   wt;
        logic                   abort_flag;
        logic [31:0][7:0]       mem;
        logic [4:0]             rd_ptr;
        logic [4:0]             wr_ptr;
        logic                   fill_done;
        logic                   loaded;
        logic [7:0]             shreg;
        logic [2:0]             bitcnt;
        logic                   sck;
        logic [7:0]             div_cnt;
        logic [7:0]             gap_cnt;
        logic                   ck_prev;
        logic [31:0]            prdata;
    } core_t;

    core_t s, next_s;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic [15:0] idx;
    logic        setup;
    logic        access;
    logic        is_buf;
    logic        mapped;
    logic        busy;
    logic        cpu_wr;
    logic [7:0]  rd_val;

    assign idx    = paddr[sbuf_pkg::ADDR_W-1:2];
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign is_buf = idx >= sbuf_pkg::IDX_BUF_LO
                 && idx <= sbuf_pkg::IDX_BUF_HI;
    assign mapped = is_buf || (idx >= sbuf_pkg::IDX_START
                 && idx <= sbuf_pkg::IDX_MODE);
    assign busy   = s.state != sbuf_pkg::ST_IDLE;
    assign cpu_wr = access && pwrite;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = s.prdata;

    always_comb begin
        rd_val = 8'h00;
        if (is_buf) begin
            rd_val = busy ? 8'h00 : s.mem[idx[4:0]];
        end else begin
            unique case (idx)
                sbuf_pkg::IDX_START: rd_val = sbuf_pkg::RSV_ONES
                    | {3'h0, s.start_ptr};
                sbuf_pkg::IDX_END:   rd_val = sbuf_pkg::RSV_ONES
                    | {3'h0, s.end_ptr};
                sbuf_pkg::IDX_CTRL:  rd_val = sbuf_pkg::RSV_ONES
                    | {3'h0, s.gap, s.cks};
                sbuf_pkg::IDX_CSR:   rd_val = sbuf_pkg::RSV_ONES
                    | {3'h0, s.tx, s.orer, s.wt, s.abort_flag, busy};
                sbuf_pkg::IDX_MODE:  rd_val = {7'h00, s.cs_mode};
                default:             rd_val = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Serial timing events
    // ----------------------------------------
    logic int_clk;
    logic tick;
    logic ext_fall;
    logic ext_rise;
    logic fall;
    logic rise;
    logic byte_done;
    logic last;
    logic gap_on;
    logic running;
    logic cs_abort;

    assign int_clk  = s.cks != sbuf_pkg::CKS_EXT;
    // Code 7 has no divider entry; gated so no unknown leaks out
    assign tick     = int_clk && s.div_cnt
                   == sbuf_pkg::DIV_HALF[s.cks] - 8'h01;
    assign ext_fall = s.ck_prev && !serial_clock_pin_in;
    assign ext_rise = !s.ck_prev && serial_clock_pin_in;
    assign running  = s.state == sbuf_pkg::ST_SHIFT
                   || s.state == sbuf_pkg::ST_GAP;
    assign fall = s.state == sbuf_pkg::ST_SHIFT && s.loaded
               && (int_clk ? tick && s.sck : ext_fall);
    assign rise = s.state == sbuf_pkg::ST_SHIFT && s.loaded
               && (int_clk ? tick && !s.sck : ext_rise);
    assign byte_done = rise && s.bitcnt == 3'h7;
    assign last      = s.wr_ptr == s.end_ptr;
    assign gap_on    = int_clk && s.gap != sbuf_pkg::GAP_NONE;
    assign cs_abort  = s.cs_mode && chip_select_n && running;

    // ----------------------------------------
    // Transmit prefetch FIFO
    // ----------------------------------------
    // Prefetch lets the next byte sit ready across the gap; it
    // stalls on full, so the buffer read pointer stays at most FIFO_DEPTH + 1 bytes ahead of the write pointer.
    logic       f_in_valid;
    logic       f_in_ready;
    logic       f_out_valid;
    logic       f_out_ready;
    logic [7:0] f_out_data;
    logic       f_clear;
    logic       push;

    assign f_in_valid  = running && !s.fill_done;
    assign f_out_ready = s.state == sbuf_pkg::ST_SHIFT && !s.loaded;
    assign f_clear     = !running;
    assign push        = f_in_valid && f_in_ready;

    sbuf_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .clear     (f_clear),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (s.mem[s.rd_ptr]),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s         = s;
        next_s.ck_prev = serial_clock_pin_in;
        if (setup) begin
            next_s.prdata = {24'h0, rd_val};
        end
        // Register writes
        if (cpu_wr) begin
            unique case (idx)
                sbuf_pkg::IDX_START: next_s.start_ptr = pwdata[4:0];
                sbuf_pkg::IDX_END:   next_s.end_ptr = pwdata[4:0];
                sbuf_pkg::IDX_CTRL: begin
                    next_s.gap = pwdata[sbuf_pkg::GAP_LSB +: 2];
                    next_s.cks = pwdata[sbuf_pkg::CKS_LSB +: 3];
                end
                sbuf_pkg::IDX_MODE:
                    next_s.cs_mode = pwdata[sbuf_pkg::CSEN_BIT];
                sbuf_pkg::IDX_CSR: begin
                    if (!pwdata[sbuf_pkg::ORER_BIT]) next_s.orer = 1'b0;
                    if (!pwdata[sbuf_pkg::WT_BIT])   next_s.wt = 1'b0;
                    if (!pwdata[sbuf_pkg::ABT_BIT])  next_s.abort_flag = 1'b0;
                    if (!busy) begin
                        next_s.tx = pwdata[sbuf_pkg::SOL_BIT];
                    end
                    if (busy && !pwdata[sbuf_pkg::STF_BIT]) begin
                        next_s.state = sbuf_pkg::ST_IDLE;
                    end else if (!busy && !s.abort_flag
                                 && pwdata[sbuf_pkg::STF_BIT]) begin
                        next_s.state = s.cs_mode ? sbuf_pkg::ST_WAIT_CS
                                                 : sbuf_pkg::ST_SHIFT;
                        next_s.rd_ptr    = s.start_ptr;
                        next_s.wr_ptr    = s.start_ptr;
                        next_s.fill_done = 1'b0;
                        next_s.loaded    = 1'b0;
                        next_s.sck       = 1'b1;
                        next_s.div_cnt   = 8'h00;
                    end
                end
                default: begin
                    if (is_buf && !busy) begin
                        next_s.mem[idx[4:0]] = pwdata[7:0];
                    end
                end
            endcase
        end
        // Buffer access while busy is dropped
        if (access && is_buf && busy) begin
            next_s.wt = 1'b1;
        end
        // Clock pulse after completion on the external clock
        if (!int_clk && s.state == sbuf_pkg::ST_IDLE && ext_fall
            && !(s.cs_mode && chip_select_n)) begin
            next_s.orer = 1'b1;
        end
        // Prefetch from the buffer
        if (push) begin
            if (s.rd_ptr == s.end_ptr) begin
                next_s.fill_done = 1'b1;
            end else begin
                next_s.rd_ptr = s.rd_ptr + 5'h01;
            end
        end
        // Divider runs only while bits or a gap are being timed
        if ((s.state == sbuf_pkg::ST_SHIFT && s.loaded)
            || s.state == sbuf_pkg::ST_GAP) begin
            next_s.div_cnt = tick ? 8'h00 : s.div_cnt + 8'h01;
        end else begin
            next_s.div_cnt = 8'h00;
        end
        unique case (s.state)
            sbuf_pkg::ST_IDLE: ;
            sbuf_pkg::ST_WAIT_CS: begin
                if (!chip_select_n) begin
                    next_s.state = sbuf_pkg::ST_SHIFT;
                end
            end
            sbuf_pkg::ST_SHIFT: begin
                if (!s.loaded && f_out_valid) begin
                    next_s.shreg  = f_out_data;
                    next_s.loaded = 1'b1;
                    next_s.bitcnt = 3'h0;
                end
                if (fall) begin
                    next_s.sck = 1'b0;
                    next_s.tx  = s.shreg[0];
                end
                if (rise) begin
                    next_s.sck    = 1'b1;
                    next_s.shreg  = {serial_rx_pin, s.shreg[7:1]};
                    next_s.bitcnt = s.bitcnt + 3'h1;
                end
                if (byte_done) begin
                    next_s.mem[s.wr_ptr] = {serial_rx_pin, s.shreg[7:1]};
                    next_s.loaded        = 1'b0;
                    if (last) begin
                        next_s.state = sbuf_pkg::ST_IDLE;
                    end else begin
                        next_s.wr_ptr = s.wr_ptr + 5'h01;
                        if (gap_on) begin
                            next_s.state   = sbuf_pkg::ST_GAP;
                            next_s.gap_cnt = 8'h00;
                        end
                    end
                end
            end
            sbuf_pkg::ST_GAP: begin
                next_s.sck = 1'b1;
                if (tick) begin
                    next_s.gap_cnt = s.gap_cnt + 8'h01;
                    if (s.gap_cnt
                        == sbuf_pkg::gap_half_ticks(s.gap) - 8'h01) begin
                        next_s.state = sbuf_pkg::ST_SHIFT;
                    end
                end
            end
        endcase
        // Chip select abort overrides any other state, abort flag or clock update
        if (cs_abort) begin
            next_s.state = sbuf_pkg::ST_IDLE;
            next_s.abort_flag   = 1'b1;
            next_s.sck   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s      <= '0;
            s.sck  <= 1'b1;
            s.ck_prev <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    // Clock and data pins float after an abort until software clears the flag
    assign serial_clock_pin_out = s.sck;
    assign serial_clock_pin_oe  = int_clk && !s.abort_flag;
    assign serial_tx_pin        = s.tx;
    assign serial_tx_pin_oe     = !s.abort_flag;
    assign byte_strobe_pin      = s.state == sbuf_pkg::ST_GAP;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence ptr_read_setup;
        setup && !pwrite
            && (idx == sbuf_pkg::IDX_START || idx == sbuf_pkg::IDX_END);
    endsequence
    sequence cs_drop;
        s.cs_mode && chip_select_n && running;
    endsequence
    // A received byte may land in the same cell in that very cycle
    sequence blocked_access;
        access && is_buf && busy && !byte_done;
    endsequence

    chk_reserved_ones: assert property (
        ptr_read_setup |=> prdata[7:5] == 3'h7)
        else $error("reserved bits not read as one");
    chk_single_byte: assert property (
        byte_done && last |=> s.state == sbuf_pkg::ST_IDLE)
        else $error("transfer did not end at end pointer");
    chk_gap_clock_high: assert property (
        s.state == sbuf_pkg::ST_GAP |-> serial_clock_pin_out)
        else $error("serial clock low during gap");
    chk_no_gap_strobe: assert property (
        s.gap == sbuf_pkg::GAP_NONE |-> !byte_strobe_pin)
        else $error("strobe high with no gap selected");
    chk_ext_no_gap: assert property (
        byte_done && !int_clk |=> s.state != sbuf_pkg::ST_GAP)
        else $error("gap inserted on external clock");
    chk_clock_pin_dir: assert property (
        s.cks == sbuf_pkg::CKS_EXT |-> !serial_clock_pin_oe)
        else $error("clock pin driven with external clock");
    chk_cs_abort: assert property (
        cs_drop |=> s.abort_flag && !busy && !serial_tx_pin_oe
                    && !serial_clock_pin_oe)
        else $error("chip select abort not taken");
    chk_wait_flag: assert property (
        blocked_access |=> s.wt
            && s.mem[$past(idx[4:0])] == $past(s.mem[idx[4:0]]))
        else $error("blocked buffer access not flagged");
    chk_ptr_step: assert property (
        byte_done && !last |=> s.wr_ptr == $past(s.wr_ptr) + 5'h01)
        else $error("buffer address did not step");

endmodule // buffered_serial_unit

`default_nettype wire

// [hw/sbuf_fifo.sv]
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; clear drops all content.
 */
`timescale 1ns/100ps
`default_nettype none

module sbuf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             clear,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_t;

    fifo_t s;
    fifo_t next_s;
    logic  push;
    logic  pop;

    assign in_ready  = s.cnt != (AW+1)'(DEPTH);
    assign out_valid = s.cnt != '0;
    assign out_data  = s.mem[s.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp        = s.wp + AW'(1);
        end
        if (pop) begin
            next_s.rp = s.rp + AW'(1);
        end
        next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (clear) begin
            next_s.wp  = '0;
            next_s.rp  = '0;
            next_s.cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule // sbuf_fifo

`default_nettype wire

// [hw/sbuf_pkg.sv]
/*
 * Constants, state encoding and lookups for the buffered serial port.
 * Assumes a single 200 MHz clock and register access over APB.
 */
// What this block does
// - Start pointer holds five bits naming the first buffer byte sent.
// - End pointer holds five bits naming the last buffer byte sent.
// - Equal start and end pointers move exactly one byte, then stop.
// - Pointer, control and status registers read ones in bits 7..5 and reset to E0; mode reads 00.
// - Gap field picks none, 8, 24 or 56 clocks between bytes.
// - Gaps only with an internal clock, never with the external one.
// - Serial clock pin stays high during an inter-byte gap.
// - Strobe stays low whenever no gap is selected.
// - Clock codes 0..6 divide the system clock by 256 down to 2.
// - Code 7 takes the external clock; else the pin drives out.
// - Pins: two-way clock, data in, data out, strobe, chip select.
// - A 32-byte read/write buffer, contents cleared to zero by reset.
// - LSB first; send on falling clock edge, sample on rising edge.
// - Start flag stays set while busy or waiting for chip select.
// - Chip select high mid-transfer aborts, flags, floats clock and data.
// - Buffer access while busy is dropped and sets the wait flag.

package sbuf_pkg;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [15:0] IDX_BUF_LO = 16'hFF80;
    localparam logic [15:0] IDX_BUF_HI = 16'hFF9F;
    localparam logic [15:0] IDX_START  = 16'hFFA4;
    localparam logic [15:0] IDX_END    = 16'hFFA5;
    localparam logic [15:0] IDX_CTRL   = 16'hFFA6;
    localparam logic [15:0] IDX_CSR    = 16'hFFA7;
    localparam logic [15:0] IDX_MODE   = 16'hFFA8;
    localparam int          ADDR_W     = 18;
    localparam int          PTR_W      = 5;

    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam logic [7:0] RSV_ONES = 8'hE0;
    localparam int GAP_LSB  = 3;
    localparam int CKS_LSB  = 0;
    localparam int SOL_BIT  = 4;
    localparam int ORER_BIT = 3;
    localparam int WT_BIT   = 2;
    localparam int ABT_BIT  = 1;
    localparam int STF_BIT  = 0;
    localparam int CSEN_BIT = 0;
    localparam logic [2:0] CKS_EXT  = 3'h7;
    localparam logic [1:0] GAP_NONE = 2'h0;

    // ----------------------------------------
    // Timing lookups
    // ----------------------------------------
    // Half serial period in system clocks, index = clock code
    localparam logic [6:0][7:0] DIV_HALF =
        {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80};
    // Gap length in serial clock cycles, index = gap code
    localparam logic [3:0][7:0] GAP_CYC = {8'h38, 8'h18, 8'h08, 8'h00};

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WAIT_CS = 2'b01,
        ST_SHIFT   = 2'b11,
        ST_GAP     = 2'b10
    } port_state_t;

    function automatic logic [7:0] gap_half_ticks(input logic [1:0] g);
        gap_half_ticks = {GAP_CYC[g][6:0], 1'b0};
    endfunction

endpackage
